// *** hbarb_top.v ***
// hbarb_top.v: pci arbitration and control of a host bridge: grants for
// five masters, hold handshake with the expansion bridge, parity, system
// error and clock-run. runs on SYS_CLK; pci pins are synchronised and the
// pci clock is sampled to find its rising edges.
//
// Overview of operation
// - one active-low grant line per request
// - on hold, drain buffers, take host bus
// - then assert active-low hold acknowledge
// - hold handshake supports passive release
// - one parity bit over address/data and command
// - assert system error on reportable errors
// - drive clock-run low to keep pci clock
// - clock-run undriven after reset release
// - pci reset clears logic asynchronously
// - pci outputs float while in reset
// - lock honoured for processor cycles only
`timescale 1ns/1ns
`include "hbarb_defs.vh"

module hbarb_top (
  input  wire        SYS_CLK,
  input  wire        RESETN,
  input  wire        PCI_CLK,
  input  wire [4:0]  REQ_N,
  output wire [4:0]  GNT_N,
  output wire [4:0]  GNT_OE_N,
  input  wire        BRIDGE_HOLD_REQUEST_N,
  output wire        BRIDGE_HOLD_ACK_N,
  output wire        BRIDGE_HOLD_ACK_OE_N,
  input  wire        FRAME_N,
  input  wire        IRDY_N,
  input  wire [31:0] AD,
  input  wire [3:0]  CBE_N,
  input  wire        PAR_I,
  output wire        PAR_O,
  output wire        PAR_OE_N,
  output wire        SERR_N_O,
  output wire        SERR_OE_N,
  input  wire        PCI_CLOCK_REQUEST_N_I,
  output wire        PCI_CLOCK_REQUEST_N_O,
  output wire        PCI_CLOCK_REQUEST_OE_N,
  output wire        LOCK_N_O,
  output wire        LOCK_OE_N,
  input  wire        WRITE_BUF_EMPTY,
  input  wire        POST_BUF_EMPTY,
  output wire        HOST_BUS_REQ,
  input  wire        HOST_BUS_GNT,
  input  wire        HOST_PCI_PENDING,
  input  wire        CPU_LOCK,
  input  wire        PASSIVE_RELEASE_EN,
  input  wire        AD_PHASE,
  input  wire        AD_DRIVE,
  input  wire        SYS_ERROR,
  output wire        PARITY_ERROR
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg  [4:0]  req_n_s1_q;
  reg  [4:0]  req_n_s2_q;
  reg  [5:0]  ctl_s1_q;
  reg  [5:0]  ctl_s2_q;
  reg  [35:0] adc_s1_q;
  reg  [35:0] adc_s2_q;
  reg         pclk_s3_q;

  wire        pclk_s2;
  wire        hold_req_s2;
  wire        frame_n_s2;
  wire        irdy_n_s2;
  wire        par_s2;
  wire        pci_clock_request_n_s2;
  wire        pci_rise;
  wire        bus_idle;
  wire [4:0]  req;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_n_s1_q <= 5'h1F;
      req_n_s2_q <= 5'h1F;
      ctl_s1_q   <= 6'h3F;
      ctl_s2_q   <= 6'h3F;
      adc_s1_q   <= 36'h0_0000_0000;
      adc_s2_q   <= 36'h0_0000_0000;
      pclk_s3_q  <= 1'b1;  // same as pclk_s2 in reset: no false edge
    end else begin
      req_n_s1_q <= REQ_N;
      req_n_s2_q <= req_n_s1_q;
      ctl_s1_q   <= {PCI_CLK, BRIDGE_HOLD_REQUEST_N, FRAME_N, IRDY_N,
                     PAR_I, PCI_CLOCK_REQUEST_N_I};
      ctl_s2_q   <= ctl_s1_q;
      adc_s1_q   <= {AD, CBE_N};
      adc_s2_q   <= adc_s1_q;
      pclk_s3_q  <= pclk_s2;
    end
  end

  assign pclk_s2     = ctl_s2_q[5];
  assign hold_req_s2 = ~ctl_s2_q[4];
  assign frame_n_s2  = ctl_s2_q[3];
  assign irdy_n_s2   = ctl_s2_q[2];
  assign par_s2      = ctl_s2_q[1];
  assign pci_clock_request_n_s2   = ctl_s2_q[0];
  assign pci_rise    = pclk_s2 & ~pclk_s3_q;
  assign bus_idle    = frame_n_s2 & irdy_n_s2;
  assign req         = ~req_n_s2_q;

  // ****************************************
  // round-robin pick
  // ****************************************
  // scans from the master after the last owner so nobody starves
  function [2:0] rr_pick;
    input [4:0] r;
    input [2:0] last;
    integer     i;
    integer     k;
    reg         found;
    begin
      rr_pick = `HBARB_IDX_ZERO;
      found   = 1'b0;
      for (i = 1; i <= `HBARB_NUM_MASTERS; i = i + 1) begin
        k = (last + i) % `HBARB_NUM_MASTERS;
        if (!found && r[k]) begin
          rr_pick = k[2:0];
          found   = 1'b1;
        end
      end
    end
  endfunction

  // ****************************************
  // arbiter and hold handshake
  // ****************************************
  reg  [4:0]  st_q;
  reg  [4:0]  st_d;
  reg  [4:0]  gnt_q;
  reg  [4:0]  gnt_d;
  reg  [2:0]  last_q;
  reg  [2:0]  last_d;
  reg         ack_q;
  reg         ack_d;
  reg         host_req_q;
  reg         host_req_d;
  reg         oe_q;
  wire [2:0]  pick;
  wire        drained;

  assign pick    = rr_pick(req, last_q);
  assign drained = WRITE_BUF_EMPTY & POST_BUF_EMPTY & HOST_BUS_GNT;

  always @* begin
    st_d       = st_q;
    gnt_d      = gnt_q;
    last_d     = last_q;
    ack_d      = ack_q;
    host_req_d = host_req_q;
    if (pci_rise) begin
      case (st_q)
        `HBARB_ST_IDLE: begin
          if (hold_req_s2) begin
            host_req_d = 1'b1;
            st_d       = `HBARB_ST_DRAIN;
          end else if (!CPU_LOCK && (|req)) begin
            gnt_d  = 5'h01 << pick;
            last_d = pick;
            st_d   = `HBARB_ST_GNT;
          end
        end
        `HBARB_ST_GNT: begin
          // grant is dropped for a full pci clock before any new one
          if (bus_idle && (hold_req_s2 || !(|(req & gnt_q)))) begin
            gnt_d = `HBARB_GNT_RST;
            st_d  = `HBARB_ST_IDLE;
          end
        end
        `HBARB_ST_DRAIN: begin
          if (!hold_req_s2) begin
            host_req_d = 1'b0;
            st_d       = `HBARB_ST_IDLE;
          end else if (drained && bus_idle) begin
            ack_d = 1'b1;
            st_d  = `HBARB_ST_HLDA;
          end
        end
        `HBARB_ST_HLDA: begin
          if (!hold_req_s2) begin
            ack_d = 1'b0;
            if (PASSIVE_RELEASE_EN) begin
              st_d = `HBARB_ST_PASV;
            end else begin
              host_req_d = 1'b0;
              st_d       = `HBARB_ST_IDLE;
            end
          end
        end
        `HBARB_ST_PASV: begin
          // host bus kept: a returning hold skips the drain if still clean
          if (hold_req_s2 && drained) begin
            ack_d = 1'b1;
            st_d  = `HBARB_ST_HLDA;
          end else if (hold_req_s2) begin
            st_d = `HBARB_ST_DRAIN;
          end else if (HOST_PCI_PENDING || (|req)) begin
            host_req_d = 1'b0;
            st_d       = `HBARB_ST_IDLE;
          end
        end
        default: begin
          gnt_d      = `HBARB_GNT_RST;
          ack_d      = 1'b0;
          host_req_d = 1'b0;
          st_d       = `HBARB_ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q       <= `HBARB_ST_IDLE;
      gnt_q      <= `HBARB_GNT_RST;
      last_q     <= `HBARB_LAST_RST;
      ack_q      <= 1'b0;
      host_req_q <= 1'b0;
      oe_q       <= 1'b0;
    end else begin
      st_q       <= st_d;
      gnt_q      <= gnt_d;
      last_q     <= last_d;
      ack_q      <= ack_d;
      host_req_q <= host_req_d;
      oe_q       <= 1'b1;
    end
  end

  assign GNT_N                = ~gnt_q;
  assign GNT_OE_N             = {`HBARB_NUM_MASTERS{~oe_q}};
  assign BRIDGE_HOLD_ACK_N    = ~ack_q;
  assign BRIDGE_HOLD_ACK_OE_N = ~oe_q;
  assign HOST_BUS_REQ         = host_req_q;

  // ****************************************
  // parity and system error
  // ****************************************
  reg  par_calc_q;
  reg  par_valid_q;
  reg  par_drive_q;
  reg  par_q;
  reg  par_oe_q;
  reg  perr_q;
  reg  serr_pend_q;
  reg  serr_q;
  wire par_bad;

  assign par_bad = pci_rise & par_valid_q & ~par_drive_q &
                   (par_s2 != par_calc_q);

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      par_calc_q  <= 1'b0;
      par_valid_q <= 1'b0;
      par_drive_q <= 1'b0;
      par_q       <= 1'b0;
      par_oe_q    <= 1'b0;
      perr_q      <= 1'b0;
      serr_pend_q <= 1'b0;
      serr_q      <= 1'b0;
    end else begin
      perr_q <= par_bad;
      if (pci_rise) begin
        par_calc_q  <= ^adc_s2_q;
        par_valid_q <= AD_PHASE;
        par_drive_q <= AD_DRIVE;
        par_q       <= par_calc_q;
        par_oe_q    <= par_valid_q & par_drive_q;
        serr_q      <= serr_pend_q | par_bad | SYS_ERROR;
      end
      // an error on a pci edge goes straight out, so clearing then is safe
      if (pci_rise) begin
        serr_pend_q <= 1'b0;
      end else if (SYS_ERROR) begin
        serr_pend_q <= 1'b1;
      end
    end
  end

  assign PAR_O        = par_q;
  assign PAR_OE_N     = ~(par_oe_q & oe_q);
  assign SERR_N_O     = 1'b0;
  assign SERR_OE_N    = ~serr_q;
  assign PARITY_ERROR = perr_q;

  // ****************************************
  // clock-run and lock
  // ****************************************
  // evaluated on SYS_CLK: the pci clock may be stopped when this is needed
  reg  pci_clock_request_n_drv_q;
  reg  lock_q;
  wire need_clk;

  assign need_clk = (|req) | hold_req_s2 | HOST_PCI_PENDING |
                    (st_q != `HBARB_ST_IDLE);

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pci_clock_request_n_drv_q <= 1'b0;
      lock_q       <= 1'b0;
    end else begin
      pci_clock_request_n_drv_q <= need_clk & (pci_clock_request_n_drv_q | pci_clock_request_n_s2);
      // pci-initiated lock is never driven or honoured
      lock_q <= CPU_LOCK & (st_q == `HBARB_ST_IDLE);
    end
  end

  assign PCI_CLOCK_REQUEST_N_O  = 1'b0;
  assign PCI_CLOCK_REQUEST_OE_N = ~pci_clock_request_n_drv_q;
  assign LOCK_N_O               = ~lock_q;
  assign LOCK_OE_N              = ~lock_q;

endmodule

// *** hbarb_defs.vh ***
// hbarb_defs.vh: constants of the host bridge pci arbitration block.
// assumes a system clock fast against the pci clock (several edges per
// pci period), so pci edges are found by sampling.
`ifndef HBARB_DEFS_VH
`define HBARB_DEFS_VH

// ****************************************
// widths
// ****************************************
`define HBARB_NUM_MASTERS  5
`define HBARB_IDX_W        3
`define HBARB_AD_W         32
`define HBARB_CBE_W        4

// ****************************************
// arbiter states, one-hot
// ****************************************
`define HBARB_ST_W         5
`define HBARB_ST_IDLE      5'h01
`define HBARB_ST_GNT       5'h02
`define HBARB_ST_DRAIN     5'h04
`define HBARB_ST_HLDA      5'h08
`define HBARB_ST_PASV      5'h10

// ****************************************
// reset values
// ****************************************
`define HBARB_GNT_RST      5'h00
`define HBARB_LAST_RST     3'h4
`define HBARB_IDX_ZERO     3'h0

`endif

// *** hbarb_chk.sv ***
// hbarb_chk.sv: port-level checks for the pci arbitration block.
// bound to hbarb_top by the bench; watches top ports only.
`timescale 1ns/1ns
module hbarb_chk (
  input logic       SYS_CLK,
  input logic       RESETN,
  input logic [4:0] REQ_N,
  input logic [4:0] GNT_N,
  input logic [4:0] GNT_OE_N,
  input logic       BRIDGE_HOLD_ACK_N,
  input logic       BRIDGE_HOLD_ACK_OE_N,
  input logic       PAR_OE_N,
  input logic       SERR_OE_N,
  input logic       PCI_CLOCK_REQUEST_N_I,
  input logic       PCI_CLOCK_REQUEST_OE_N,
  input logic       WRITE_BUF_EMPTY,
  input logic       POST_BUF_EMPTY,
  input logic       HOST_BUS_REQ,
  input logic       CPU_LOCK,
  input logic       SYS_ERROR,
  input logic       PARITY_ERROR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // ****
  // checks
  // ****
  one_owner_a: assert property ($onehot0({~GNT_N, ~BRIDGE_HOLD_ACK_N}))
    else $error("two bus owners");
  float_rst_a: assert property (disable iff (1'h0) !RESETN |->
    &{GNT_OE_N, BRIDGE_HOLD_ACK_OE_N, PAR_OE_N, SERR_OE_N, GNT_N})
    else $error("pin driven in reset");
  drain_ack_a: assert property ($fell(BRIDGE_HOLD_ACK_N) |->
    $past(WRITE_BUF_EMPTY && POST_BUF_EMPTY)) else $error("ack undrained");
  host_bus_a: assert property (!BRIDGE_HOLD_ACK_N |-> HOST_BUS_REQ)
    else $error("ack without host bus");
  lock_block_a: assert property ($fell(&GNT_N) |-> $past(!CPU_LOCK))
    else $error("grant under lock");
  grant_gap_a: assert property ($rose(&GNT_N) |-> (&GNT_N) [*3])
    else $error("no gap between grants");
  serr_raise_a: assert property ((SYS_ERROR || PARITY_ERROR) |->
    ##[1:40] !SERR_OE_N) else $error("error not reported");
  clk_run_a: assert property ((REQ_N != 5'h1f && PCI_CLOCK_REQUEST_N_I)
    |-> ##[1:6] !PCI_CLOCK_REQUEST_OE_N) else $error("clock run idle");
  cover property ($fell(BRIDGE_HOLD_ACK_N));
  cover property ($fell(&GNT_N));
  cover property ($fell(SERR_OE_N));
endmodule

// *** hbarb_peer.sv ***
// hbarb_peer.sv: pci masters and expansion bridge facing the arbiter.
// the bench sets want/hold_want; pins change after the falling edge.
`timescale 1ns/1ns
module hbarb_peer (
  input  logic       clk,
  input  logic [4:0] want,
  input  logic       hold_want,
  input  logic [4:0] gnt_n,
  output logic [4:0] req_n = 5'h1f,
  output logic       hold_n = 1'h1,
  output logic       frame_n = 1'h1,
  output logic       irdy_n = 1'h1
);
  // ****
  // far side
  // ****
  always @(negedge clk) begin
    req_n <= ~want;
    hold_n <= ~hold_want;
    // owner keeps the bus busy until it lets its request go
    frame_n <= ~|(want & ~gnt_n);
    irdy_n <= ~|(want & ~gnt_n);
  end
endmodule

// *** hbarb_top_test.sv ***
// hbarb_top_test.sv: self-checking bench for the arbitration block.
// needs hbarb_top, hbarb_peer, hbarb_chk; the pci clock is made here.
`timescale 1ns/1ns
module hbarb_top_test;
  logic        clk = 1'h0, rst_n = 1'h1, pclk = 1'h0, hold_want = 1'h0;
  logic        wbe = 1'h0, pbe = 1'h0, hbg = 1'h0, lock = 1'h0;
  logic        pre = 1'h0, adp = 1'h0, add = 1'h0, sys_err = 1'h0;
  logic        par_i = 1'h0, pend = 1'h0;
  logic [4:0]  want = 5'h00;
  logic [31:0] ad = 32'h0000_0000;
  logic [3:0]  cbe_n = 4'hf;
  wire  [4:0]  req_n, gnt_n, gnt_oe_n;
  wire         hold_n, frame_n, irdy_n, ack_n, ack_oe_n, par_o, par_oe_n;
  wire         serr_o, serr_oe_n, cr_o, cr_oe_n, lock_o, lock_oe_n, hbr;
  wire         perr;
  wire         gnt = gnt_n != 5'h1f;
  // open-drain clock-run line with its pull-up
  wire         cr_pin = cr_oe_n ? 1'h1 : cr_o;
  int          fail_count = 0, n_tests = 0, i;
  always #5 clk = ~clk;
  // 125 ns pci clock, phase unrelated to clk
  always begin
    #62 pclk = 1'h1;
    #63 pclk = 1'h0;
  end
  hbarb_top i_hbarb_top (
    .SYS_CLK(clk), .RESETN(rst_n), .PCI_CLK(pclk), .REQ_N(req_n),
    .GNT_N(gnt_n), .GNT_OE_N(gnt_oe_n), .BRIDGE_HOLD_REQUEST_N(hold_n),
    .BRIDGE_HOLD_ACK_N(ack_n), .BRIDGE_HOLD_ACK_OE_N(ack_oe_n),
    .FRAME_N(frame_n), .IRDY_N(irdy_n), .AD(ad), .CBE_N(cbe_n),
    .PAR_I(par_i), .PAR_O(par_o), .PAR_OE_N(par_oe_n),
    .SERR_N_O(serr_o), .SERR_OE_N(serr_oe_n),
    .PCI_CLOCK_REQUEST_N_I(cr_pin), .PCI_CLOCK_REQUEST_N_O(cr_o),
    .PCI_CLOCK_REQUEST_OE_N(cr_oe_n), .LOCK_N_O(lock_o),
    .LOCK_OE_N(lock_oe_n), .WRITE_BUF_EMPTY(wbe), .POST_BUF_EMPTY(pbe),
    .HOST_BUS_REQ(hbr), .HOST_BUS_GNT(hbg), .HOST_PCI_PENDING(pend),
    .CPU_LOCK(lock), .PASSIVE_RELEASE_EN(pre), .AD_PHASE(adp),
    .AD_DRIVE(add), .SYS_ERROR(sys_err), .PARITY_ERROR(perr));
  hbarb_peer i_hbarb_peer (.clk(clk), .want(want), .hold_want(hold_want),
    .gnt_n(gnt_n), .req_n(req_n), .hold_n(hold_n), .frame_n(frame_n),
    .irdy_n(irdy_n));
  // ****
  // scenarios
  // ****
  task automatic chk(input string nm, input logic [35:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task t_grant;
    want = 5'h1f;
    repeat (6) @(negedge clk);
    chk("crun", {cr_oe_n, cr_o}, 2'h0);
    for (int k = 0; k < 5; k++) begin
      for (i = 0; i < 99 && !gnt; i++) @(negedge clk);
      chk("rr", gnt_n, 5'h1f ^ (5'h01 << k));
      want[k] = 1'h0;
      for (i = 0; i < 99 && gnt; i++) @(negedge clk);
    end
  endtask
  task t_async;
    want = 5'h04;
    for (i = 0; i < 99 && !gnt; i++) @(negedge clk);
    chk("gnt2", gnt_n, 5'h1b);
    want = 5'h00;
    rst_n = 1'h0;
    #1 chk("async", {gnt_oe_n, ack_oe_n, gnt_n}, 11'h7ff);
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
  endtask
  task t_hold;
    pre = 1'h1;
    hold_want = 1'h1;
    for (i = 0; i < 99 && !hbr; i++) @(negedge clk);
    chk("hreq", hbr, 1'h1);
    want = 5'h02;
    repeat (60) @(negedge clk);
    chk("drain", {ack_n, gnt_n}, 6'h3f);
    {wbe, pbe, hbg} = 3'h7;
    for (i = 0; i < 99 && ack_n; i++) @(negedge clk);
    chk("ack", {ack_n, gnt_n}, 6'h1f);
    want = 5'h00;
    hold_want = 1'h0;
    for (i = 0; i < 99 && !ack_n; i++) @(negedge clk);
    chk("pasv", {ack_n, hbr}, 2'h3);
    hold_want = 1'h1;
    repeat (40) @(negedge clk);
    chk("reack", ack_n, 1'h0);
    hold_want = 1'h0;
    want = 5'h02;
    for (i = 0; i < 99 && !gnt; i++) @(negedge clk);
    chk("free", {hbr, gnt_n}, 6'h1d);
    want = 5'h00;
    for (i = 0; i < 99 && gnt; i++) @(negedge clk);
    // passive release left by pending host traffic
    hold_want = 1'h1;
    for (i = 0; i < 99 && ack_n; i++) @(negedge clk);
    hold_want = 1'h0;
    repeat (40) @(negedge clk);
    chk("kept", {ack_n, hbr}, 2'h3);
    pend = 1'h1;
    for (i = 0; i < 99 && hbr; i++) @(negedge clk);
    chk("pend", hbr, 1'h0);
    pend = 1'h0;
    // plain hold: host bus goes back with the acknowledge
    pre = 1'h0;
    hold_want = 1'h1;
    for (i = 0; i < 99 && ack_n; i++) @(negedge clk);
    chk("ack2", {ack_n, hbr}, 2'h1);
    hold_want = 1'h0;
    for (i = 0; i < 99 && !ack_n; i++) @(negedge clk);
    chk("noref", {ack_n, hbr}, 2'h2);
  endtask
  task t_lock;
    lock = 1'h1;
    want = 5'h08;
    repeat (60) @(negedge clk);
    chk("lock", {lock_oe_n, lock_o, gnt_n}, 7'h1f);
    lock = 1'h0;
    for (i = 0; i < 99 && !gnt; i++) @(negedge clk);
    chk("unlock", gnt_n, 5'h17);
    want = 5'h00;
  endtask
  task t_par;
    ad = 32'ha5c3_0f71;
    cbe_n = 4'h7;
    // let the new address pass the pin synchronisers first
    repeat (3) @(negedge clk);
    {adp, add} = 2'h3;
    for (i = 0; i < 99 && par_oe_n; i++) @(negedge clk);
    chk("par", {par_oe_n, par_o}, {1'h0, ^{ad, cbe_n}});
    add = 1'h0;
    par_i = ~^{ad, cbe_n};
    for (i = 0; i < 99 && !perr; i++) @(negedge clk);
    chk("perr", perr, 1'h1);
    for (i = 0; i < 99 && serr_oe_n; i++) @(negedge clk);
    chk("serr", {serr_oe_n, serr_o}, 2'h0);
    adp = 1'h0;
    // let parity reports already taken into serr_q run out first
    repeat (60) @(negedge clk);
    chk("serr_off", serr_oe_n, 1'h1);
    sys_err = 1'h1;
    @(negedge clk);
    sys_err = 1'h0;
    for (i = 0; i < 99 && serr_oe_n; i++) @(negedge clk);
    chk("serr_sys", serr_oe_n, 1'h0);
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    // a real falling edge, so the first clock edge already sees reset
    #1 rst_n = 1'h0;
    repeat (16) @(negedge clk);
    chk("float", {gnt_oe_n, ack_oe_n, par_oe_n, serr_oe_n, cr_oe_n},
        9'h1ff);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    chk("idle", {gnt_n, ack_n, cr_oe_n, gnt_oe_n}, 12'hfe0);
    t_grant;
    t_async;
    t_hold;
    t_lock;
    t_par;
    results;
  end
  initial begin
    #500_000;
    fail_count++;
    results;
  end
endmodule
bind hbarb_top hbarb_chk i_hbarb_chk (.*);
